// ===== rmw_ctrl.sv
/*
 * Mode and wake controller of a transparent serial radio modem.
 * Assumes byte-level UART and radio engines on the same mclk domain.
 */
`default_nettype none
// What this block does
// R1: standard mode relays bytes between host port and radio unchanged.
// R2: standard mode pulls wake pin low a lead time before host-bound data.
// R3: low power mode keeps host port on and samples channel periodically.
// R4: activity in low power mode enables receiver and forwards payload to host.
// R5: low power mode drives wake pin low lead time before delivering data.
// R6: sleep mode keeps host port off, only channel monitor runs.
// R7: sleep mode enables host port when radio activity is detected.
// R8: sleep mode closes port after one idle second, resumes monitoring.
// R9: system must never put both link ends in sleep mode.
// R10: low power and sleep interoperate; neither talks to standard mode.
// R11: host may change operating parameters over serial port.
// R12: configuration traffic runs at fixed 9600 bit/s, no parity; block forces it after the first frame byte, not while END_LF goes out.
// R13: command qualifier 0x80 from host, answer carries 0x00.
// R14: serial rate code 1 to 7 selects 1200 to 57600 bit/s.
// R15: wake pin stays high while no host transfer is pending.
// R16: one timebase for lead and idle; idle restarts on every byte.
module rmw_ctrl import rmw_pkg::*; #(
  parameter int LEAD_CYCLES = LEAD_CYC,
  parameter int IDLE_CYCLES = IDLE_CYC,
  parameter int MON_CYCLES = MON_CYC
) (
  input wire logic mclk,                  // 25 MHz clock
  input wire logic srst,                  // synchronous reset, high
  input wire rmw_byte_type host_rx,       // byte from host uart receiver
  input wire logic host_tx_ready,         // host uart transmitter free
  output rmw_byte_type host_tx,           // byte toward host
  input wire rmw_byte_type radio_rx,      // byte from radio receiver
  output logic radio_rx_ready,            // block can take a radio byte
  output rmw_byte_type radio_tx,          // byte toward radio
  input wire logic chan_active,           // channel_activity_monitor hit
  output logic mon_sample,                // channel_activity_monitor strobe
  output logic rx_enable,                 // receive circuit on
  output logic host_port_en,              // host serial port on
  output logic wake_n,                    // wake indicator, low = pending
  output logic [2:0] baud_code,           // host serial rate code
  output rmw_mode_type mode               // current operating mode
);
  localparam int LW = $clog2(LEAD_CYCLES + 1);
  localparam int IW = $clog2(IDLE_CYCLES + 1);
  localparam int MW = $clog2(MON_CYCLES + 1);

  rmw_mode_type mode_ff;
  rmw_dlv_type dlv_ff, nxt_dlv;
  rmw_byte_type hold_ff, host_tx_ff, radio_tx_ff;
  logic [LW-1:0] lead_cnt_ff;
  logic [IW-1:0] idle_cnt_ff;
  logic [MW-1:0] mon_cnt_ff;
  logic awake_ff, port_en_ff, rx_en_ff, wake_n_ff, rdy_ff, mon_ff;
  logic [3:0] pidx_ff, ridx_ff;
  logic [7:0] type_ff;
  logic [2:0] baud_ff, baud_new_ff, baud_out_ff;
  logic prev_cr_ff, rsp_act_ff;
  logic host_in, take_radio, load_rsp, host_out, traffic, monitoring;
  logic [7:0] rsp_byte;

  assign host_in = host_rx.valid && port_en_ff;
  assign take_radio = radio_rx.valid && rdy_ff;
  assign load_rsp = rsp_act_ff && !take_radio && dlv_ff == DLV_IDLE;
  assign host_out = host_tx_ff.valid && host_tx_ready;
  assign traffic = host_in || host_out || dlv_ff != DLV_IDLE;
  assign monitoring = mode_ff != MODE_STD && !awake_ff;

  // ****************************************************************
  // transparent relay toward the radio
  // ****************************************************************
  // R1: host bytes pass unchanged
  always_ff @(posedge mclk) begin
    if (srst) begin
      radio_tx_ff <= '0;
    end else begin
      radio_tx_ff.valid <= host_in;
      radio_tx_ff.data <= host_rx.data;
    end
  end

  // ****************************************************************
  // delivery toward the host with wake lead
  // ****************************************************************
  // next delivery state; each byte gets its own lead so the host never misses one
  always_comb begin
    nxt_dlv = dlv_ff;
    case (dlv_ff)
      DLV_IDLE: begin
        if (take_radio || load_rsp) begin
          nxt_dlv = DLV_LEAD;
        end
      end
      DLV_LEAD: begin
        if (lead_cnt_ff == LW'(LEAD_CYCLES - 1)) begin
          nxt_dlv = DLV_SEND;
        end
      end
      DLV_SEND: begin
        if (host_out) begin
          nxt_dlv = DLV_IDLE;
        end
      end
      default: nxt_dlv = DLV_IDLE;
    endcase
  end

  // R4: radio payload captured for the host
  always_ff @(posedge mclk) begin
    if (srst) begin
      dlv_ff <= DLV_IDLE;
      hold_ff <= '0;
      rdy_ff <= 1'b0;
    end else begin
      dlv_ff <= nxt_dlv;
      rdy_ff <= nxt_dlv == DLV_IDLE && !(rsp_act_ff && !take_radio);
      if (take_radio) begin
        hold_ff <= '{valid: 1'b1, data: radio_rx.data};
      end else if (load_rsp) begin
        hold_ff <= '{valid: 1'b1, data: rsp_byte};
      end else if (host_out) begin
        hold_ff.valid <= 1'b0;
      end
    end
  end

  // R16: lead time from the shared clock count
  always_ff @(posedge mclk) begin
    if (srst || dlv_ff != DLV_LEAD) begin
      lead_cnt_ff <= '0;
    end else begin
      lead_cnt_ff <= lead_cnt_ff + LW'(1);
    end
  end

  // R2: wake pin low through lead and send
  // R5: same lead in low power mode
  // R15: high whenever nothing is pending
  always_ff @(posedge mclk) begin
    if (srst) begin
      wake_n_ff <= 1'b1;
      host_tx_ff <= '0;
    end else begin
      wake_n_ff <= nxt_dlv == DLV_IDLE;
      host_tx_ff.valid <= nxt_dlv == DLV_SEND;
      host_tx_ff.data <= hold_ff.data;
    end
  end

  // ****************************************************************
  // channel monitor, wake and idle timeout
  // ****************************************************************
  // R3: periodic channel sampling while not awake
  always_ff @(posedge mclk) begin
    if (srst || !monitoring) begin
      mon_cnt_ff <= '0;
      mon_ff <= 1'b0;
    end else begin
      mon_ff <= mon_cnt_ff == MW'(MON_CYCLES - 1);
      mon_cnt_ff <= (mon_cnt_ff == MW'(MON_CYCLES - 1)) ? '0 : mon_cnt_ff + MW'(1);
    end
  end

  // R7: activity opens the port
  // R8: idle second closes it again
  // R16: idle count restarts on every byte
  always_ff @(posedge mclk) begin
    if (srst || mode_ff == MODE_STD) begin
      awake_ff <= 1'b0;
      idle_cnt_ff <= '0;
    end else if (monitoring) begin
      awake_ff <= chan_active;
      idle_cnt_ff <= '0;
    end else if (traffic || rsp_act_ff) begin
      idle_cnt_ff <= '0;
    end else if (idle_cnt_ff == IW'(IDLE_CYCLES - 1)) begin
      awake_ff <= 1'b0;
      idle_cnt_ff <= '0;
    end else begin
      idle_cnt_ff <= idle_cnt_ff + IW'(1);
    end
  end

  // R3: low power keeps port on
  // R6: sleep keeps port off until woken
  always_ff @(posedge mclk) begin
    if (srst) begin
      port_en_ff <= 1'b1;
      rx_en_ff <= 1'b1;
    end else begin
      port_en_ff <= mode_ff != MODE_SLEEP || awake_ff;
      rx_en_ff <= mode_ff == MODE_STD || awake_ff;
    end
  end

  // ****************************************************************
  // configuration frames from the host
  // ****************************************************************
  // R11: frame parser; a mismatch restarts the hunt for the sync byte
  // R13: qualifier must be the command value
  always_ff @(posedge mclk) begin
    if (srst) begin
      pidx_ff <= '0;
      type_ff <= '0;
      baud_new_ff <= BAUD_CFG;
      prev_cr_ff <= 1'b0;
    end else if (host_in) begin
      prev_cr_ff <= host_rx.data == END_CR;
      case (pidx_ff)
        4'h0, 4'h1, POS_HDR: begin
          pidx_ff <= (host_rx.data == SYNC_BYTE) ? pidx_ff + 4'h1 : 4'h0;
        end
        POS_ID0, POS_ID1: begin
          pidx_ff <= (host_rx.data == ID_BYTE) ? pidx_ff + 4'h1 : 4'h0;
        end
        POS_QUAL: begin
          pidx_ff <= (host_rx.data == QUAL_CMD) ? POS_TYPE : 4'h0;
        end
        POS_TYPE: begin
          type_ff <= host_rx.data;
          pidx_ff <= POS_LEN;
        end
        POS_LEN: pidx_ff <= POS_DATA;
        POS_DATA: begin
          baud_new_ff <= host_rx.data[2:0];
          pidx_ff <= POS_TAIL;
        end
        default: begin
          if (prev_cr_ff && host_rx.data == END_LF) begin
            pidx_ff <= '0;
          end
        end
      endcase
    end
  end

  // R14: only codes 1 to 7 are accepted
  // R11: a closed frame applies mode or rate and starts the answer
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_ff <= MODE_STD;
      baud_ff <= BAUD_CFG;
      rsp_act_ff <= 1'b0;
    end else if (host_in && pidx_ff == POS_TAIL && prev_cr_ff && host_rx.data == END_LF) begin
      rsp_act_ff <= 1'b1;
      case (type_ff)
        CMD_STD: mode_ff <= MODE_STD;
        CMD_LP: mode_ff <= MODE_LP;
        CMD_SLEEP: mode_ff <= MODE_SLEEP;
        CMD_WRITE: begin
          if (baud_new_ff >= BAUD_MIN && baud_new_ff <= BAUD_MAX) begin
            baud_ff <= baud_new_ff;
          end
        end
        default: mode_ff <= mode_ff;
      endcase
    end else if (load_rsp && ridx_ff == POS_LAST) begin
      rsp_act_ff <= 1'b0;
    end
  end

  // answer byte counter advances as each byte enters delivery
  always_ff @(posedge mclk) begin
    if (srst || !rsp_act_ff) begin
      ridx_ff <= '0;
    end else if (load_rsp) begin
      ridx_ff <= ridx_ff + 4'h1;
    end
  end

  // R13: answer frame with zero qualifier; checksum is the type byte
  always_comb begin
    case (ridx_ff)
      POS_ID0, POS_ID1: rsp_byte = ID_BYTE;
      POS_QUAL: rsp_byte = QUAL_RSP;
      POS_TYPE, POS_CS: rsp_byte = type_ff;
      POS_LEN: rsp_byte = RSP_LEN_BYTE;
      POS_CR: rsp_byte = END_CR;
      POS_LAST: rsp_byte = END_LF;
      default: rsp_byte = SYNC_BYTE;
    endcase
  end

  // R12: fixed config rate after the first frame byte until the answer's END_LF enters delivery
  always_ff @(posedge mclk) begin
    if (srst) begin
      baud_out_ff <= BAUD_CFG;
    end else begin
      baud_out_ff <= (pidx_ff != '0 || rsp_act_ff) ? BAUD_CFG : baud_ff;
    end
  end

  assign host_tx = host_tx_ff;
  assign radio_tx = radio_tx_ff;
  assign radio_rx_ready = rdy_ff;
  assign mon_sample = mon_ff;
  assign rx_enable = rx_en_ff;
  assign host_port_en = port_en_ff;
  assign wake_n = wake_n_ff;
  assign baud_code = baud_out_ff;
  assign mode = mode_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // helper: cycles the wake pin has been low, saturates just past the lead
  logic [LW:0] low_cnt_ff;
  always_ff @(posedge mclk) begin
    if (srst || wake_n_ff) begin
      low_cnt_ff <= '0;
    end else if (low_cnt_ff <= (LW+1)'(LEAD_CYCLES)) begin
      low_cnt_ff <= low_cnt_ff + (LW+1)'(1);
    end
  end

  a_wake_lead: assert property ($rose(host_tx_ff.valid) |->  // R2
    low_cnt_ff >= (LW+1)'(LEAD_CYCLES))
    else $error("host byte sent before wake lead elapsed");
  a_lp_lead: assert property (mode_ff == MODE_LP && take_radio |=> !wake_n_ff [*2])  // R5
    else $error("wake pin not low after low power capture");
  a_wake_idle: assert property (host_tx_ff.valid |-> !wake_n_ff)  // R15
    else $error("byte offered to host while wake pin high");
  a_relay_byte: assert property (host_in |=>  // R1
    radio_tx_ff.valid && radio_tx_ff.data == $past(host_rx.data))
    else $error("host byte not relayed");
  a_lp_port_on: assert property (mode_ff == MODE_LP |=> port_en_ff)  // R3
    else $error("port off in low power mode");
  a_sleep_port: assert property (mode_ff == MODE_SLEEP && !awake_ff ##1  // R6
    mode_ff == MODE_SLEEP |-> !port_en_ff)
    else $error("port on while asleep");
  a_sleep_wake: assert property (monitoring && mode_ff == MODE_SLEEP && chan_active  // R7
    ##1 mode_ff == MODE_SLEEP |=> port_en_ff)
    else $error("port not opened on activity");
  a_idle_close: assert property (awake_ff && !monitoring && !traffic && !rsp_act_ff  // R8
    && idle_cnt_ff == IW'(IDLE_CYCLES - 1) |=> !awake_ff)
    else $error("port not closed after idle timeout");
  a_lp_receive: assert property (take_radio |=> dlv_ff == DLV_LEAD && hold_ff.valid)  // R4
    else $error("radio byte not queued for host");
  a_cfg_rate: assert property (rsp_act_ff |=> baud_out_ff == BAUD_CFG)  // R12
    else $error("config answer not at fixed rate");
  a_rate_range: assert property (baud_out_ff >= BAUD_MIN && baud_out_ff <= BAUD_MAX)  // R14
    else $error("rate code out of range");
  a_rsp_qual: assert property (load_rsp && ridx_ff == POS_QUAL |=> hold_ff.data == QUAL_RSP)  // R13
    else $error("answer qualifier wrong");

  c_lp_delivery: cover property (mode_ff == MODE_LP && host_out);
  c_sleep_cycle: cover property (mode_ff == MODE_SLEEP && $fell(awake_ff));
  c_cfg_answer: cover property ($fell(rsp_act_ff));
  c_mode_change: cover property ($changed(mode_ff));
endmodule
`default_nettype wire

// ===== rmw_host_model.sv
/*
 * Host side model: a serial transmitter that takes bytes bound for the host.
 * Assumes the mclk domain and the byte handshake of the controller's host port.
 */
`default_nettype none
module rmw_host_model import rmw_pkg::*; (
  input wire logic mclk,             // 25 MHz clock
  input wire logic srst,             // synchronous reset, high
  input wire rmw_byte_type host_tx,  // byte offered to host
  input wire logic [3:0] stall,      // busy cycles after each byte
  output logic host_tx_ready,        // transmitter free
  output rmw_byte_type got           // byte taken, one-cycle pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // transmitter
  // ****************************************************************
  logic [3:0] busy_ff;
  // host takes whole bytes by handshake; serial rate and parity are not modelled
  // busy for stall cycles after each byte so a slow host is tested as well as a prompt one
  always @(posedge mclk) begin
    if (srst) begin
      host_tx_ready <= 1'b0;
      got <= '0;
      busy_ff <= 4'h0;
    end else if (host_tx.valid && host_tx_ready) begin
      got <= {1'b1, host_tx.data};
      busy_ff <= stall;
      host_tx_ready <= 1'b0;
    end else begin
      got.valid <= 1'b0;
      if (busy_ff != 4'h0) busy_ff <= busy_ff - 4'h1;
      else host_tx_ready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== rmw_pkg.sv
/*
 * Constants and types shared by the radio modem mode and wake controller.
 * Assumes a single 25 MHz clock; long counts are re-exposed as top parameters.
 */
`default_nettype none
package rmw_pkg;
  // ****************************************************************
  // timebase
  // ****************************************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int LEAD_TIME_US = 2000;        // wake lead time, 2 ms
  localparam int IDLE_TIME_MS = 1000;        // sleep idle timeout, 1 s
  localparam int MON_PERIOD_MS = 100;        // channel monitor period
  localparam int LEAD_CYC = LEAD_TIME_US * (CLK_HZ / 1_000_000);
  localparam int IDLE_CYC = IDLE_TIME_MS * (CLK_HZ / 1000);
  localparam int MON_CYC = MON_PERIOD_MS * (CLK_HZ / 1000);

  // ****************************************************************
  // configuration frame layout
  // ****************************************************************
  localparam logic [7:0] SYNC_BYTE = 8'haf;
  localparam logic [7:0] ID_BYTE = 8'h00;
  localparam logic [7:0] QUAL_CMD = 8'h80;
  localparam logic [7:0] QUAL_RSP = 8'h00;
  localparam logic [7:0] END_CR = 8'h0d;
  localparam logic [7:0] END_LF = 8'h0a;
  localparam logic [7:0] RSP_LEN_BYTE = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_STD = 8'h03;
  localparam logic [7:0] CMD_LP = 8'h04;
  localparam logic [7:0] CMD_SLEEP = 8'h05;
  localparam logic [3:0] POS_ID0 = 4'h2;
  localparam logic [3:0] POS_ID1 = 4'h3;
  localparam logic [3:0] POS_HDR = 4'h4;
  localparam logic [3:0] POS_QUAL = 4'h5;
  localparam logic [3:0] POS_TYPE = 4'h6;
  localparam logic [3:0] POS_LEN = 4'h7;
  localparam logic [3:0] POS_DATA = 4'h8;
  localparam logic [3:0] POS_CS = 4'h8;
  localparam logic [3:0] POS_CR = 4'h9;
  localparam logic [3:0] POS_LAST = 4'ha;
  localparam logic [3:0] POS_TAIL = 4'h9;

  // ****************************************************************
  // serial rate codes
  // ****************************************************************
  localparam logic [2:0] BAUD_MIN = 3'h1;    // 1200 bit/s
  localparam logic [2:0] BAUD_MAX = 3'h7;    // 57600 bit/s
  localparam logic [2:0] BAUD_CFG = 3'h4;    // 9600 bit/s, fixed for config

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_STD = 2'b00,
    MODE_LP = 2'b01,
    MODE_SLEEP = 2'b11
  } rmw_mode_type;

  typedef enum logic [1:0] {
    DLV_IDLE = 2'b00,
    DLV_LEAD = 2'b01,
    DLV_SEND = 2'b11
  } rmw_dlv_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rmw_byte_type;
endpackage
`default_nettype wire

// ===== tb_top.sv
/*
 * Self-checking bench for the mode and wake controller.
 * Assumes short timer parameters; host handshake comes from rmw_host_model.
 */
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top import rmw_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LEAD_P = 8;
  localparam int IDLE_P = 40;
  localparam int MON_P = 16;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  rmw_byte_type host_rx = '0, radio_rx = '0, host_tx, radio_tx, got;
  logic host_tx_ready, chan_active = 1'b0, radio_rx_ready, mon_sample, rx_enable;
  logic host_port_en, wake_n;
  logic [2:0] baud_code;
  logic [3:0] stall = 4'h0;
  rmw_mode_type mode;
  int bad_count = 0, samples_checked = 0, lead_cnt = 0, lead_bad = 0;
  logic [7:0] hq[$], rq[$];
  // ****************************************************************
  // instances
  // ****************************************************************
  rmw_ctrl #(.LEAD_CYCLES(LEAD_P), .IDLE_CYCLES(IDLE_P), .MON_CYCLES(MON_P)) i_rmw_ctrl (
    .mclk(mclk), .srst(srst), .host_rx(host_rx), .host_tx_ready(host_tx_ready),
    .host_tx(host_tx), .radio_rx(radio_rx), .radio_rx_ready(radio_rx_ready),
    .radio_tx(radio_tx), .chan_active(chan_active), .mon_sample(mon_sample),
    .rx_enable(rx_enable), .host_port_en(host_port_en), .wake_n(wake_n),
    .baud_code(baud_code), .mode(mode));
  rmw_host_model i_rmw_host_model (.mclk(mclk), .srst(srst), .host_tx(host_tx),
    .stall(stall), .host_tx_ready(host_tx_ready), .got(got));
  // clock, 40 ns period
  always #20 mclk = ~mclk;
  // collect bytes at both ends; lead is wake low cycles before data shows
  always @(posedge mclk) begin
    if (got.valid) hq.push_back(got.data);
    if (radio_tx.valid === 1'b1) rq.push_back(radio_tx.data);
    if (wake_n === 1'b1) lead_cnt = 0;
    else if (host_tx.valid !== 1'b1) lead_cnt++;
    else if (lead_cnt != 0) begin
      if (lead_cnt != LEAD_P) lead_bad++;
      lead_cnt = 0;
    end
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang(input int n);
    bad_count++;
    $display("ERROR t=%0t got=%h exp=%h", $time, hq.size(), n);
    end_of_test();
  endtask
  // back to back host bytes, one per cycle
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      host_rx = {1'b1, b[i]};
      tick(1);
    end
    host_rx = {1'b0, ~host_rx.data};
  endtask
  task automatic wait_host(input int n);
    for (int i = 0; i < 3000 && hq.size() < n; i++) tick(1);
    if (hq.size() < n) hang(n);
  endtask
  task automatic pulse_chan();
    chan_active = 1'b1;
    tick(1);
    chan_active = 1'b0;
    tick(2);
  endtask
  // configuration frame, answer compared byte for byte
  task automatic frame(input logic [7:0] yy, input logic [7:0] d0);
    logic [7:0] ans[$];
    ans = {SYNC_BYTE, SYNC_BYTE, ID_BYTE, ID_BYTE, SYNC_BYTE, QUAL_RSP, yy, RSP_LEN_BYTE,
      yy, END_CR, END_LF};
    hq.delete();
    rq.delete();
    stall = 4'h3;
    send({SYNC_BYTE, SYNC_BYTE, ID_BYTE, ID_BYTE, SYNC_BYTE, QUAL_CMD, yy, 8'h01, d0,
      8'h00, END_CR, END_LF});
    wait_host(11);
    tick(3);
    stall = 4'h0;
    `CHK(rq.size(), 12)
    `CHK(hq.size(), 11)
    foreach (ans[i]) `CHK(hq[i], ans[i])
    `CHK(wake_n, 1'b1)
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    `CHK(mode, MODE_STD)
    `CHK(baud_code, BAUD_CFG)
    `CHK(wake_n, 1'b1)
    `CHK(host_port_en, 1'b1)
    `CHK(rx_enable, 1'b1)
    $display("test reset done");
  endtask
  task automatic t_relay();
    logic [7:0] sent[$];
    sent = {8'h5a, 8'ha5, 8'h00, 8'hff};
    rq.delete();
    send(sent);
    tick(3);
    `CHK(rq.size(), 4)
    foreach (sent[i]) `CHK(rq[i], sent[i])
    $display("test relay done");
  endtask
  // radio byte held until taken, then delivered with wake lead
  task automatic deliver(input logic [7:0] d);
    int i;
    hq.delete();
    radio_rx = {1'b1, d};
    for (i = 0; i < 300 && radio_rx_ready !== 1'b1; i++) tick(1);
    tick(1);
    radio_rx = {1'b0, ~d};
    if (i == 300) hang(0);
    `CHK(wake_n, 1'b0)
    wait_host(1);
    tick(2);
    `CHK(hq[0], d)
    `CHK(wake_n, 1'b1)
    `CHK(lead_bad, 0)
  endtask
  task automatic t_std_deliver();
    deliver(8'hc3);
    $display("test standard delivery done");
  endtask
  task automatic t_baud();
    frame(CMD_WRITE, 8'h07);
    `CHK(baud_code, BAUD_MAX)
    frame(CMD_WRITE, 8'h00);
    `CHK(baud_code, BAUD_MAX)
    frame(CMD_WRITE, 8'h01);
    `CHK(baud_code, BAUD_MIN)
    // a read request is only answered, it changes neither rate nor mode
    frame(8'h02, 8'h00);
    `CHK(baud_code, BAUD_MIN)
    `CHK(mode, MODE_STD)
    $display("test rate codes done");
  endtask
  task automatic t_low_power();
    int n = 0;
    frame(CMD_LP, 8'h00);
    `CHK(mode, MODE_LP)
    tick(IDLE_P + 10);
    `CHK(host_port_en, 1'b1)
    `CHK(rx_enable, 1'b0)
    for (int i = 0; i < 4 * MON_P; i++) begin
      tick(1);
      n += int'(mon_sample === 1'b1);
    end
    `CHK(n, 4)
    pulse_chan();
    `CHK(rx_enable, 1'b1)
    deliver(8'h3c);
    $display("test low power done");
  endtask
  task automatic t_sleep();
    frame(CMD_SLEEP, 8'h00);
    `CHK(mode, MODE_SLEEP)
    tick(IDLE_P + 10);
    `CHK(host_port_en, 1'b0)
    rq.delete();
    send({8'h11});
    tick(3);
    `CHK(rq.size(), 0)
    pulse_chan();
    `CHK(host_port_en, 1'b1)
    tick(30);
    send({8'h22});
    tick(30);
    `CHK(host_port_en, 1'b1)
    tick(IDLE_P);
    `CHK(host_port_en, 1'b0)
    pulse_chan();
    frame(CMD_STD, 8'h00);
    `CHK(mode, MODE_STD)
    `CHK(rx_enable, 1'b1)
    $display("test sleep done");
  endtask
  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    tick(20);
    srst = 1'b0;
    tick(2);
    t_reset();
    t_relay();
    t_std_deliver();
    t_baud();
    t_low_power();
    t_sleep();
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    hang(-1);
  end
endmodule
`default_nettype wire
